// file: rtl/osrb_pkg.sv
// constants, register map and timing shared by both ends of the sensor register link
//
// Notes on behaviour
// - host writes key 0x5A to 0x09 first
// - page select 0x01 at 0x7F selects page one
// - page select 0x00 returns to page zero
// - host never writes undefined register addresses
// - product code split across offsets 0x00, 0x01
// - power-down entered within 1.9 ms of request
// - contact indication valid 10 to 38 ms after power
// - host waits 2.75 us between address and data
// - host idles link 1 us before next transaction
// - watchdog drops stalled serial transaction after 1 ms
// - wakeup interrupt 310 us after wake request
// - strap chooses I2C, 4-wire or 2-wire SPI; the strap only sets link_mode, the link always runs 4-wire
package osrb_pkg;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [6:0] A_PCODE_HI  = 7'h00;
   localparam logic [6:0] A_PCODE_LO  = 7'h01;
   localparam logic [6:0] A_OPMODE    = 7'h05;
   localparam logic [6:0] A_CONFIG    = 7'h06;
   localparam logic [6:0] A_UNLOCK    = 7'h09;
   localparam logic [6:0] A_SLEEP1    = 7'h0A;
   localparam logic [6:0] A_ENTER     = 7'h0B;
   localparam logic [6:0] A_SLEEP2    = 7'h0C;
   localparam logic [6:0] A_AE_EN     = 7'h20;
   localparam logic [6:0] A_EXPO_L    = 7'h32;
   localparam logic [6:0] A_EXPO_H    = 7'h33;
   localparam logic [6:0] A_CRES      = 7'h4D;
   localparam logic [6:0] A_CSTAT     = 7'h59;
   localparam logic [6:0] A_PULSE_A   = 7'h1A;
   localparam logic [6:0] A_FMEAN     = 7'h1B;
   localparam logic [6:0] A_PULSE_C   = 7'h1C;
   localparam logic [6:0] A_CTH       = 7'h23;
   localparam logic [6:0] A_CTH_L     = 7'h25;
   localparam logic [6:0] A_CTH_H     = 7'h26;
   localparam logic [6:0] A_EMIT      = 7'h38;
   localparam logic [6:0] A_RAW_A     = 7'h64;
   localparam logic [6:0] A_RAW_B     = 7'h65;
   localparam logic [6:0] A_RAW_C     = 7'h66;
   localparam logic [6:0] A_RAW_D     = 7'h67;
   localparam logic [6:0] A_PVALID    = 7'h68;
   localparam logic [6:0] A_PAGE      = 7'h7F;
   localparam logic [7:0] UNLOCK_KEY  = 8'h5A;
   localparam logic [7:0] PAGE_ZERO   = 8'h00;
   localparam logic [7:0] PAGE_ONE    = 8'h01;
   // ----------------------------------------
   // reset values and fields
   // ----------------------------------------
   localparam logic [7:0] R_OPMODE    = 8'hB8;
   localparam logic [7:0] R_CONFIG    = 8'h02;
   localparam logic [7:0] R_UNLOCK    = 8'h00;
   localparam logic [7:0] R_SLEEP1    = 8'h21;
   localparam logic [7:0] R_ENTER     = 8'h37;
   localparam logic [7:0] R_SLEEP2    = 8'h71;
   localparam logic [7:0] R_AE_EN     = 8'h0F;
   localparam logic [7:0] R_CRES      = 8'h1A;
   localparam logic [7:0] R_CTH       = 8'h28;
   localparam logic [7:0] R_CTH_L     = 8'h00;
   localparam logic [7:0] R_CTH_H     = 8'h02;
   localparam logic [7:0] R_EMIT      = 8'hF2;
   localparam int         CFG_PD_BIT  = 3;
   localparam int         WR_FLAG_BIT = 7;
   // strap codes: low, floating, high
   localparam logic [1:0] MODE_I2C    = 2'h0;
   localparam logic [1:0] MODE_SPI4   = 2'h1;
   localparam logic [1:0] MODE_SPI2   = 2'h2;
   // ----------------------------------------
   // timing, 50 MHz core clock
   // ----------------------------------------
   localparam int CLK_NS       = 20;
   localparam int T_DELAY_NS   = 2750;
   localparam int T_RESYNC_NS  = 1000;
   localparam int T_SCLK_H_NS  = 500;
   localparam int T_PD_MAX_NS  = 1900000;
   localparam int T_PU_MIN_NS  = 10000000;
   localparam int T_WDOG_NS    = 1000000;
   localparam int T_WAKE_NS    = 310000;
   localparam int DELAY_CYC    = (T_DELAY_NS + CLK_NS - 1) / CLK_NS;
   localparam int RESYNC_CYC   = (T_RESYNC_NS + CLK_NS - 1) / CLK_NS;
   localparam int SCLK_H_CYC   = (T_SCLK_H_NS + CLK_NS - 1) / CLK_NS;
   localparam int PD_CYC       = T_PD_MAX_NS / CLK_NS;
   localparam int PU_CYC       = (T_PU_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int WDOG_CYC     = T_WDOG_NS / CLK_NS;
   localparam int WAKE_CYC     = T_WAKE_NS / CLK_NS;

   // true for every address that exists in the selected page
   function automatic logic reg_defined(input logic pg, input logic [6:0] a);
      if (a == A_PAGE)
         return 1'b1;
      if (!pg)
         return a inside {A_PCODE_HI, A_PCODE_LO, A_OPMODE, A_CONFIG, A_UNLOCK,
                          A_SLEEP1, A_ENTER, A_SLEEP2, A_AE_EN, A_EXPO_L,
                          A_EXPO_H, A_CRES, A_CSTAT};
      return (a inside {A_PULSE_A, A_FMEAN, A_PULSE_C, A_CTH, A_CTH_L, A_CTH_H,
                        A_EMIT, A_PVALID}) || (a >= A_RAW_A && a <= A_RAW_D);
   endfunction
endpackage

// file: rtl/osrb_link_if.sv
// serial link between the host end and the sensor register end
`timescale 1ns/1ps
interface osrb_link_if;
   logic sclk;
   logic cs_n;
   logic mosi;
   logic miso;
   logic miso_oe;

   modport dev
   (
      input  sclk,
      input  cs_n,
      input  mosi,
      output miso,
      output miso_oe
   );

   modport host
   (
      output sclk,
      output cs_n,
      output mosi,
      input  miso,
      input  miso_oe
   );
endinterface

// file: rtl/osrb_dev.sv
// sensor-side register bank with serial slave, power and wake timing
`timescale 1ns/1ps
module osrb_dev
   import osrb_pkg::*;
#(
   parameter logic [11:0] PRODUCT_CODE     = 12'h0A5C, // arbitrary
   parameter logic [3:0]  SILICON_REVISION = 4'h1,     // arbitrary
   parameter int          PD_LAT           = PD_CYC,
   parameter int          PU_LAT           = PU_CYC,
   parameter int          WDOG_LAT         = WDOG_CYC,
   parameter int          WAKE_LAT         = WAKE_CYC
)
(
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       srst,
   // link
   osrb_link_if.dev        lnk,
   // strap
   input  wire logic [1:0] interface_select_strap,
   output logic [1:0]      link_mode,
   // sensor results
   input  wire logic [15:0] exposure_time,
   input  wire logic [7:0]  contact_status,
   input  wire logic [7:0]  pulse_a,
   input  wire logic [7:0]  frame_mean,
   input  wire logic [7:0]  pulse_c,
   input  wire logic [31:0] pulse_raw,
   input  wire logic [7:0]  pulse_valid,
   // power and wake
   input  wire logic       wake_req,
   output logic            power_down,
   output logic            contact_valid,
   output logic            wake_irq,
   // configuration seen by the sensor core
   output logic [7:0]      opmode,
   output logic [7:0]      config_bits
);
   import osrb_pkg::*;

   typedef enum logic [3:0]
   {
      D_IDLE  = 4'b0001,
      D_ADDR  = 4'b0010,
      D_DATA  = 4'b0100,
      D_ABORT = 4'b1000
   } osrb_dst_e;

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [2:0] sck_s, cs_s, mo_s;
   logic       sck_f, cs_f, mo_f;
   logic       sck_rise, sck_fall;
   logic       sck_f_q, cs_f_q;

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         sck_s <= 3'h0;
         cs_s  <= 3'h7;
         mo_s  <= 3'h0;
      end
      else
      begin
         sck_s <= {sck_s[1:0], lnk.sclk};
         cs_s  <= {cs_s[1:0], lnk.cs_n};
         mo_s  <= {mo_s[1:0], lnk.mosi};
      end
   end

   // a level counts once the second and third stages agree
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         sck_f_q <= 1'b0;
         cs_f_q  <= 1'b1;
         mo_f    <= 1'b0;
      end
      else
      begin
         if (sck_s[1] == sck_s[2])
            sck_f_q <= sck_s[2];
         if (cs_s[1] == cs_s[2])
            cs_f_q <= cs_s[2];
         if (mo_s[1] == mo_s[2])
            mo_f <= mo_s[2];
      end
   end

   assign sck_f = sck_s[2];
   assign cs_f  = cs_s[2];
   assign sck_rise = (sck_f == sck_s[1]) && sck_f && !sck_f_q;
   assign sck_fall = (sck_f == sck_s[1]) && !sck_f && sck_f_q;

   // ----------------------------------------
   // frame sequencing
   // ----------------------------------------
   osrb_dst_e  st_q;
   logic [2:0] bit_q;
   logic [7:0] sh_q;
   logic [7:0] cmd_q;
   logic [7:0] rd_q;
   logic       dshift_q;
   logic [31:0] wd_q;
   logic       wr_go;
   logic [7:0] rd_d;
   logic       cs_act;

   assign cs_act = !cs_f_q && !((cs_f == cs_s[1]) && cs_f);

   // watchdog restarts on every clock edge of the link
   always_ff @(posedge core_clk)
   begin
      if (srst || cs_f_q || sck_rise || sck_fall)
         wd_q <= 32'h0000_0000;
      else if (wd_q < 32'(WDOG_LAT))
         wd_q <= wd_q + 32'h0000_0001;
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
         st_q <= D_IDLE;
      else if (!cs_act)
         st_q <= D_IDLE;
      else
         unique case (st_q)
            D_IDLE:  st_q <= D_ADDR;
            D_ADDR:  if (wd_q == 32'(WDOG_LAT))
                        st_q <= D_ABORT;
                     else if (sck_rise && bit_q == 3'h7)
                        st_q <= D_DATA;
            D_DATA:  if (wd_q == 32'(WDOG_LAT))
                        st_q <= D_ABORT;
                     else if (sck_rise && bit_q == 3'h7)
                        st_q <= D_IDLE;
            D_ABORT: st_q <= D_ABORT;
         endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (srst || st_q == D_IDLE)
      begin
         bit_q <= 3'h0;
         sh_q  <= 8'h00;
      end
      else if (sck_rise)
      begin
         bit_q <= bit_q + 3'h1;
         sh_q  <= {sh_q[6:0], mo_f};
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
         cmd_q <= 8'h00;
      else if (st_q == D_ADDR && sck_rise && bit_q == 3'h7)
         cmd_q <= {sh_q[6:0], mo_f};
   end

   // read data is captured when the address completes and shifted out msb first
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         rd_q     <= 8'h00;
         dshift_q <= 1'b0;
      end
      else if (st_q == D_ADDR && sck_rise && bit_q == 3'h7)
      begin
         rd_q     <= rd_d;
         dshift_q <= 1'b0;
      end
      else if (st_q == D_DATA && sck_rise)
         dshift_q <= 1'b1;
      else if (st_q == D_DATA && sck_fall && dshift_q)
         rd_q <= {rd_q[6:0], 1'b0};
   end

   assign lnk.miso    = rd_q[7];
   assign lnk.miso_oe = (st_q == D_DATA) && !cmd_q[WR_FLAG_BIT];

   assign wr_go = st_q == D_DATA && sck_rise && bit_q == 3'h7 && cmd_q[WR_FLAG_BIT];

   // ----------------------------------------
   // register file
   // ----------------------------------------
   logic [7:0] page_q, unlock_q, sleep1_q, enter_q, sleep2_q, ae_q, cres_q;
   logic [7:0] cth_q, cthl_q, cthh_q;
   logic [7:0] wdat;
   logic [6:0] wadr;
   logic       pg;
   logic       wr_ok;

   assign wdat = {sh_q[6:0], mo_f};
   assign wadr = cmd_q[6:0];
   assign pg   = page_q == PAGE_ONE;
   // locked writes are dropped, but the key and page registers stay open
   assign wr_ok = wr_go && (unlock_q == UNLOCK_KEY || wadr == A_UNLOCK
                            || wadr == A_PAGE);

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         page_q   <= PAGE_ZERO;
         unlock_q <= R_UNLOCK;
         opmode   <= R_OPMODE;
         config_bits <= R_CONFIG;
         sleep1_q <= R_SLEEP1;
         enter_q  <= R_ENTER;
         sleep2_q <= R_SLEEP2;
         ae_q     <= R_AE_EN;
         cres_q   <= R_CRES;
         cth_q    <= R_CTH;
         cthl_q   <= R_CTH_L;
         cthh_q   <= R_CTH_H;
      end
      else if (wr_ok)
      begin
         if (wadr == A_PAGE && (wdat == PAGE_ZERO || wdat == PAGE_ONE))
            page_q <= wdat;
         else if (!pg)
            unique case (wadr)
               A_UNLOCK: unlock_q <= wdat;
               A_OPMODE: opmode <= wdat;
               A_CONFIG: config_bits <= wdat;
               A_SLEEP1: sleep1_q <= wdat;
               A_ENTER:  enter_q <= wdat;
               A_SLEEP2: sleep2_q <= wdat;
               A_AE_EN:  ae_q <= wdat;
               A_CRES:   cres_q <= wdat;
               default:  ;
            endcase
         else
            unique case (wadr)
               A_CTH:   cth_q <= wdat;
               A_CTH_L: cthl_q <= wdat;
               A_CTH_H: cthh_q <= wdat;
               default: ;
            endcase
      end
   end

   always_comb
   begin
      rd_d = 8'h00;
      if ({sh_q[6:0], mo_f} == {1'b0, A_PAGE})
         rd_d = page_q;
      else if (!pg)
         unique case ({sh_q[5:0], mo_f})
            A_PCODE_HI: rd_d = PRODUCT_CODE[11:4];
            A_PCODE_LO: rd_d = {PRODUCT_CODE[3:0], SILICON_REVISION};
            A_OPMODE:   rd_d = opmode;
            A_CONFIG:   rd_d = config_bits;
            A_UNLOCK:   rd_d = unlock_q;
            A_SLEEP1:   rd_d = sleep1_q;
            A_ENTER:    rd_d = enter_q;
            A_SLEEP2:   rd_d = sleep2_q;
            A_AE_EN:    rd_d = ae_q;
            A_EXPO_L:   rd_d = exposure_time[7:0];
            A_EXPO_H:   rd_d = exposure_time[15:8];
            A_CRES:     rd_d = cres_q;
            A_CSTAT:    rd_d = contact_valid ? contact_status : 8'h00;
            default:    rd_d = 8'h00;
         endcase
      else
         unique case ({sh_q[5:0], mo_f})
            A_PULSE_A:  rd_d = pulse_a;
            A_FMEAN:    rd_d = frame_mean;
            A_PULSE_C:  rd_d = pulse_c;
            A_CTH:      rd_d = cth_q;
            A_CTH_L:    rd_d = cthl_q;
            A_CTH_H:    rd_d = cthh_q;
            A_EMIT:     rd_d = R_EMIT;
            A_RAW_A:    rd_d = pulse_raw[7:0];
            A_RAW_B:    rd_d = pulse_raw[15:8];
            A_RAW_C:    rd_d = pulse_raw[23:16];
            A_RAW_D:    rd_d = pulse_raw[31:24];
            A_PVALID:   rd_d = pulse_valid;
            default:    rd_d = 8'h00;
         endcase
   end

   // ----------------------------------------
   // power, wake and strap timing
   // ----------------------------------------
   logic [31:0] pd_q, pu_q, wk_q;
   logic        wk_run_q, strap_done_q;

   always_ff @(posedge core_clk)
   begin
      if (srst || !config_bits[CFG_PD_BIT])
      begin
         pd_q       <= 32'h0000_0000;
         power_down <= 1'b0;
      end
      else if (pd_q < 32'(PD_LAT - 1))
         pd_q <= pd_q + 32'h0000_0001;
      else
         power_down <= 1'b1;
   end

   // contact indication is held off for the least power-up time
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         pu_q          <= 32'h0000_0000;
         contact_valid <= 1'b0;
      end
      else if (pu_q < 32'(PU_LAT - 1))
         pu_q <= pu_q + 32'h0000_0001;
      else
         contact_valid <= 1'b1;
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         wk_q     <= 32'h0000_0000;
         wk_run_q <= 1'b0;
         wake_irq <= 1'b0;
      end
      else
      begin
         wake_irq <= 1'b0;
         if (wake_req && !wk_run_q)
         begin
            wk_run_q <= 1'b1;
            wk_q     <= 32'h0000_0000;
         end
         else if (wk_run_q && wk_q == 32'(WAKE_LAT - 2))
         begin
            wk_run_q <= 1'b0;
            wake_irq <= 1'b1;
         end
         else if (wk_run_q)
            wk_q <= wk_q + 32'h0000_0001;
      end
   end

   // the strap is a pin: three stages, free running so they settle during reset
   logic [1:0] strap_s0, strap_s1, strap_s2;

   always_ff @(posedge core_clk)
   begin
      strap_s0 <= interface_select_strap;
      strap_s1 <= strap_s0;
      strap_s2 <= strap_s1;
   end

   // the strap is caught once after reset release, when the last two stages agree
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         strap_done_q <= 1'b0;
         link_mode    <= MODE_SPI4;
      end
      else if (!strap_done_q && strap_s1 == strap_s2)
      begin
         strap_done_q <= 1'b1;
         link_mode    <= strap_s2;
      end
   end
endmodule // osrb_dev

// file: rtl/osrb_host.sv
// host-side serial master for the sensor register bank
`timescale 1ns/1ps
module osrb_host
   import osrb_pkg::*;
(
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       srst,
   // link
   osrb_link_if.host       lnk,
   // command port
   input  wire logic       cmd_valid,
   output logic            cmd_ready,
   input  wire logic       cmd_write,
   input  wire logic [6:0] cmd_addr,
   input  wire logic [7:0] cmd_wdata,
   // answer
   output logic            rsp_valid,
   output logic [7:0]      rsp_rdata,
   output logic            cmd_refused
);
   import osrb_pkg::*;

   typedef enum logic [4:0]
   {
      H_IDLE   = 5'b00001,
      H_ADDR   = 5'b00010,
      H_GAP    = 5'b00100,
      H_DATA   = 5'b01000,
      H_RESYNC = 5'b10000
   } osrb_hst_e;

   osrb_hst_e  st_q;
   logic [7:0] tx_q, rx_q, wd_q;
   logic       wr_q, page_q;
   logic [3:0] edg_q;
   logic [7:0] tm_q;
   logic [2:0] mi_s;
   logic       mi_f;
   logic       take, tick;

   assign cmd_ready = st_q == H_IDLE;
   // writes outside the selected page's map never reach the link
   assign take = cmd_valid && cmd_ready
                 && !(cmd_write && !reg_defined(page_q, cmd_addr));
   assign tick = tm_q == 8'(SCLK_H_CYC - 1);

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         mi_s <= 3'h0;
         mi_f <= 1'b0;
      end
      else
      begin
         mi_s <= {mi_s[1:0], lnk.miso};
         if (mi_s[1] == mi_s[2])
            mi_f <= mi_s[2];
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
         cmd_refused <= 1'b0;
      else
         cmd_refused <= cmd_valid && cmd_ready && !take;
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         st_q     <= H_IDLE;
         tm_q     <= 8'h00;
         edg_q    <= 4'h0;
         tx_q     <= 8'h00;
         rx_q     <= 8'h00;
         wd_q     <= 8'h00;
         wr_q     <= 1'b0;
         lnk.sclk <= 1'b0;
         lnk.cs_n <= 1'b1;
      end
      else
         unique case (st_q)
            H_IDLE:
               if (take)
               begin
                  st_q     <= H_ADDR;
                  tx_q     <= {cmd_write, cmd_addr};
                  wd_q     <= cmd_wdata;
                  wr_q     <= cmd_write;
                  lnk.cs_n <= 1'b0;
                  tm_q     <= 8'h00;
                  edg_q    <= 4'h0;
               end
            H_ADDR, H_DATA:
               if (!tick)
                  tm_q <= tm_q + 8'h01;
               else
               begin
                  tm_q     <= 8'h00;
                  edg_q    <= edg_q + 4'h1;
                  lnk.sclk <= !lnk.sclk;
                  if (!lnk.sclk)
                     rx_q <= {rx_q[6:0], mi_f};
                  else
                     tx_q <= {tx_q[6:0], 1'b0};
                  if (edg_q == 4'hF)
                  begin
                     st_q  <= st_q == H_ADDR ? H_GAP : H_RESYNC;
                     tx_q  <= wd_q;
                     edg_q <= 4'h0;
                     if (st_q == H_DATA)
                        lnk.cs_n <= 1'b1;
                  end
               end
            H_GAP:
               if (tm_q == 8'(DELAY_CYC - 1))
               begin
                  st_q <= H_DATA;
                  tm_q <= 8'h00;
               end
               else
                  tm_q <= tm_q + 8'h01;
            H_RESYNC:
               if (tm_q == 8'(RESYNC_CYC - 1))
               begin
                  st_q <= H_IDLE;
                  tm_q <= 8'h00;
               end
               else
                  tm_q <= tm_q + 8'h01;
         endcase
   end

   assign lnk.mosi = tx_q[7];

   // the page is tracked so that writes can be checked against the right map
   always_ff @(posedge core_clk)
   begin
      if (srst)
         page_q <= 1'b0;
      else if (take && cmd_write && cmd_addr == A_PAGE)
         page_q <= cmd_wdata == PAGE_ONE;
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         rsp_valid <= 1'b0;
         rsp_rdata <= 8'h00;
      end
      else
      begin
         rsp_valid <= st_q == H_RESYNC && tm_q == 8'(RESYNC_CYC - 1);
         if (st_q == H_RESYNC && tm_q == 8'h00)
            rsp_rdata <= wr_q ? 8'h00 : rx_q;
      end
   end
endmodule // osrb_host

// file: sim/osrb_props.sv
// link checker for the sensor register serial link
`timescale 1ns/1ps
module osrb_props
(
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // link
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic miso,
   input wire logic miso_oe
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   // ----
   // helpers
   // ----
   logic       sclk_q;
   logic       chg;
   logic       wr_q;
   logic [5:0] edges_q;
   logic [7:0] idle_q;
   assign chg = sclk != sclk_q;
   always_ff @(posedge core_clk) sclk_q <= sclk;
   // idle count saturates so long quiet spells never wrap into a short one
   always_ff @(posedge core_clk)
   begin
      if (srst)
         idle_q <= 8'hff;
      else if (chg)
         idle_q <= 8'h00;
      else if (idle_q != 8'hff)
         idle_q <= idle_q + 8'h01;
   end
   always_ff @(posedge core_clk)
   begin
      if (srst || (cs_n && !chg))
         edges_q <= 6'h00;
      else if (chg)
         edges_q <= edges_q + 6'h01;
   end
   always_ff @(posedge core_clk)
   begin
      if (chg && sclk && edges_q == 6'h00)
         wr_q <= mosi;
   end
   // ----
   // properties
   // ----
   sequence s_quiet;
      (cs_n && !sclk) [*8];
   endsequence
   property p_idle_low; cs_n |-> !sclk; endproperty
   property p_resync; $fell(cs_n) |-> idle_q >= 8'h31; endproperty
   property p_gap; chg && edges_q == 6'h10 |-> idle_q >= 8'h89; endproperty
   property p_frame; $rose(cs_n) |-> chg && edges_q == 6'h1f ##1 s_quiet; endproperty
   property p_mosi; !cs_n && sclk |-> $stable(mosi); endproperty
   property p_miso; edges_q > 6'h10 && sclk && miso_oe |-> $stable(miso); endproperty
   property p_oe_read; miso_oe |-> !cs_n && !wr_q; endproperty
   property p_reset; disable iff (1'b0) srst |=> cs_n && !sclk && !miso_oe; endproperty
   a_idle_low: assert property (p_idle_low)
      else $error("sclk not low outside frame");
   a_resync: assert property (p_resync)
      else $error("frame started too soon");
   a_gap: assert property (p_gap)
      else $error("address to data gap too short");
   a_frame: assert property (p_frame)
      else $error("frame edge count wrong");
   a_mosi: assert property (p_mosi)
      else $error("mosi moved while sclk high");
   a_miso: assert property (p_miso)
      else $error("miso moved while sclk high");
   a_oe_read: assert property (p_oe_read)
      else $error("miso driven outside read");
   a_reset: assert property (p_reset)
      else $error("link not idle after reset");
endmodule // osrb_props

// file: sim/optical_sensor_register_bank_tb.sv
// self-checking bench for both ends of the sensor register link
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
   $display("wrong value %s exp %h got %h", n, e, g); end end
module optical_sensor_register_bank_tb;
   import osrb_pkg::*;
   localparam logic [11:0] PCODE = 12'h0a5c; // arbitrary
   localparam logic [3:0]  REV   = 4'h3;     // arbitrary
   logic        core_clk, srst, wake_req, power_down, contact_valid, wake_irq;
   logic        cmd_valid, cmd_ready, cmd_write, rsp_valid, cmd_refused, ref_seen;
   logic [1:0]  strap, link_mode;
   logic [6:0]  cmd_addr;
   logic [7:0]  cmd_wdata, rsp_rdata, opmode, cfg;
   logic [31:0] sens;
   int          mismatches, compares, n;
   osrb_link_if lnk();
   osrb_dev #(.PRODUCT_CODE(PCODE), .SILICON_REVISION(REV), .PD_LAT(40), .PU_LAT(100),
      .WDOG_LAT(2000), .WAKE_LAT(30)) osrb_dev_inst (.core_clk(core_clk), .srst(srst),
      .lnk(lnk), .interface_select_strap(strap), .link_mode(link_mode),
      .exposure_time(sens[15:0]), .contact_status(sens[31:24]), .pulse_a(sens[7:0]),
      .frame_mean(sens[15:8]), .pulse_c(sens[23:16]), .pulse_raw(sens),
      .pulse_valid(~sens[7:0]), .wake_req(wake_req), .power_down(power_down),
      .contact_valid(contact_valid), .wake_irq(wake_irq), .opmode(opmode), .config_bits(cfg));
   osrb_host osrb_host_inst (.core_clk(core_clk), .srst(srst), .lnk(lnk),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
      .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .cmd_refused(cmd_refused));
   osrb_props osrb_props_inst (.core_clk(core_clk), .srst(srst), .sclk(lnk.sclk),
      .cs_n(lnk.cs_n), .mosi(lnk.mosi), .miso(lnk.miso), .miso_oe(lnk.miso_oe));
   // ----
   // tasks
   // ----
   task automatic stop_test();
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // one command at a time; the next is only issued once the answer is back
   task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] d);
      cmd_valid = 1'b1;
      cmd_write = w;
      cmd_addr = a;
      cmd_wdata = d;
      @(posedge core_clk) #1;
      cmd_valid = 1'b0;
      n = 0;
      while (rsp_valid !== 1'b1 && cmd_refused !== 1'b1 && n < 2000)
      begin
         @(posedge core_clk) #1;
         n++;
      end
      ref_seen = cmd_refused;
      `CHK("answer", 1'b1, n < 2000)
      // a clock edge separates this request from the next, even after a refusal
      @(posedge core_clk) #1;
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      xfer(1'b0, a, 8'h00);
      `CHK($sformatf("reg %h", a), e, rsp_rdata)
   endtask
   // ----
   // stimulus
   // ----
   initial
   begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   initial
   begin
      #1_000_000;
      mismatches++;
      stop_test();
   end
   initial
   begin
      {srst, cmd_valid, cmd_write, cmd_addr, cmd_wdata, wake_req} = '0;
      sens = 32'h3c5a_96e1;
      for (int s = 0; s < 3; s++)
      begin
         strap = s[1:0];
         srst = 1'b1;
         repeat (2) @(posedge core_clk);
         #1 srst = 1'b0;
         repeat (2) @(posedge core_clk) #1;
         `CHK("link mode", s[1:0], link_mode)
      end
      `CHK("contact early", 1'b0, contact_valid)
      rd(A_PCODE_HI, PCODE[11:4]);
      rd(A_PCODE_LO, {PCODE[3:0], REV});
      `CHK("contact late", 1'b1, contact_valid)
      rd(A_CSTAT, sens[31:24]);
      xfer(1'b1, A_OPMODE, 8'h55);
      rd(A_OPMODE, R_OPMODE);
      xfer(1'b1, A_UNLOCK, UNLOCK_KEY);
      xfer(1'b1, A_OPMODE, 8'h55);
      rd(A_OPMODE, 8'h55);
      `CHK("opmode", 8'h55, opmode)
      xfer(1'b1, A_PCODE_LO, 8'hff);
      rd(A_PCODE_LO, {PCODE[3:0], REV});
      xfer(1'b1, A_CONFIG, R_CONFIG | 8'h08);
      `CHK("config", R_CONFIG | 8'h08, cfg)
      `CHK("power down", 1'b1, power_down)
      xfer(1'b1, A_CONFIG, R_CONFIG);
      `CHK("power up", 1'b0, power_down)
      xfer(1'b1, A_PAGE, PAGE_ONE);
      rd(A_EMIT, R_EMIT);
      rd(A_CTH, R_CTH);
      rd(A_RAW_C, sens[23:16]);
      xfer(1'b1, A_OPMODE, 8'h00);
      `CHK("refused", 1'b1, ref_seen)
      `CHK("ready", 1'b1, cmd_ready)
      xfer(1'b1, A_PAGE, PAGE_ZERO);
      rd(A_CONFIG, R_CONFIG);
      rd(A_EXPO_H, sens[15:8]);
      wake_req = 1'b1;
      @(posedge core_clk) #1;
      wake_req = 1'b0;
      n = 1;
      while (wake_irq !== 1'b1 && n < 100)
      begin
         @(posedge core_clk) #1;
         n++;
      end
      `CHK("wake delay", 1'b1, n >= 30 && n <= 32)
      stop_test();
   end
endmodule // optical_sensor_register_bank_tb
